// File: src/modem_ctrl_pkg.sv
// What this block does
// - Control word 1180 hex holds the device in reset while powered up
// - Transmit word 1E05 hex sends a fixed 1209 Hz tone at 0 dB
// - Level field 111 gives 0 dB, 000 gives -10.5 dB
// - Tone code 01010 sends a fixed 2100 Hz answer tone
// - Mode 0100 is V.23 FSK 75 bps; low bits 011 send ones
// - Tone code 11101 sends DTMF digit A while it stays written
// - Tone code 11110 sends DTMF digit B while it stays written
// - Tone code 00000 silences the transmitter at once
`default_nettype none
package modem_ctrl_pkg;

    localparam longint CLK_HZ = 100_000_000;
    localparam int PHASE_W = 24;

    // Register indices as printed; byte address is four times the index
    localparam logic [7:0] IDX_GEN_CTRL = 8'hE0;
    localparam logic [7:0] IDX_TX_MODE = 8'hE1;
    localparam logic [7:0] IDX_STATUS = 8'hF0;
    localparam logic [11:0] ADDR_GEN_CTRL = {2'h0, IDX_GEN_CTRL, 2'h0};
    localparam logic [11:0] ADDR_TX_MODE = {2'h0, IDX_TX_MODE, 2'h0};
    localparam logic [11:0] ADDR_STATUS = {2'h0, IDX_STATUS, 2'h0};

    localparam logic [15:0] GEN_CTRL_RESET = 16'h0000;
    localparam logic [15:0] TX_MODE_RESET = 16'h0000;

    // General control fields
    localparam int GC_MASK_MSB = 5;
    localparam int GC_IRQEN_BIT = 6;
    localparam int GC_RESET_BIT = 7;
    localparam int GC_POWER_BIT = 8;
    localparam int GC_HOOK_BIT = 9;
    localparam int GC_EQDIS_BIT = 10;
    localparam int GC_LOOP_BIT = 11;
    localparam int GC_XTAL_BIT = 12;

    // Transmit mode fields
    localparam int TM_MODE_MSB = 15;
    localparam int TM_MODE_LSB = 12;
    localparam int TM_LVL_MSB = 11;
    localparam int TM_LVL_LSB = 9;
    localparam int TM_GUARD_BIT = 8;
    localparam int TM_TONE_MSB = 4;
    localparam int TM_FSK_MSB = 2;

    typedef enum logic [3:0] {
        TXM_TONE = 4'h1,
        TXM_FSK75 = 4'h4
    } tx_mode_t;

    localparam logic [4:0] TONE_NONE = 5'h00;
    localparam logic [4:0] TONE_1209 = 5'h05;
    localparam logic [4:0] TONE_2100 = 5'h0A;
    localparam logic [4:0] TONE_DTMF_A = 5'h1D;
    localparam logic [4:0] TONE_DTMF_B = 5'h1E;
    localparam logic [2:0] FSK_CONT_ONES = 3'h3;
    localparam logic [2:0] LVL_0DB = 3'h7;
    localparam logic [2:0] LVL_MIN = 3'h0;

    localparam int HZ_1209 = 1209;
    localparam int HZ_2100 = 2100;
    localparam int HZ_697 = 697;
    localparam int HZ_770 = 770;
    localparam int HZ_1633 = 1633;
    localparam int HZ_FSK75_MARK = 390;

    // Square-wave peak: one tone full, each half of a pair at half
    localparam logic [15:0] AMP_SINGLE = 16'h4000;
    localparam logic [15:0] AMP_DUAL = 16'h2000;
    localparam int GAIN_SHIFT = 15;

    function automatic logic [PHASE_W-1:0] phase_inc(input int hz);
        longint t;
        t = (longint'(hz) <<< PHASE_W) / CLK_HZ;
        return t[PHASE_W-1:0];
    endfunction : phase_inc

    // Q15 gain in 1.5 dB steps from -10.5 dB up to 0 dB
    function automatic logic [15:0] level_gain(input logic [2:0] lvl);
        case (lvl)
            3'h7: return 16'h7FFF;
            3'h6: return 16'h6BB3;
            3'h5: return 16'h5A9E;
            3'h4: return 16'h4C3F;
            3'h3: return 16'h4027;
            3'h2: return 16'h35FA;
            3'h1: return 16'h2D6B;
            default: return 16'h2637;
        endcase
    endfunction : level_gain

endpackage : modem_ctrl_pkg
`default_nettype wire

// File: src/tone_synth.sv
`default_nettype none
module tone_synth
    import modem_ctrl_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic tone_on,
    input wire logic tone_dual,
    input wire logic [PHASE_W-1:0] inc_a,
    input wire logic [PHASE_W-1:0] inc_b,
    input wire logic [15:0] gain,
    output logic signed [15:0] tx_sample,
    output logic tx_active
);

    logic [PHASE_W-1:0] phase_a_reg, phase_a_next;
    logic [PHASE_W-1:0] phase_b_reg, phase_b_next;
    logic signed [15:0] sample_reg, sample_next;
    logic active_reg, active_next;
    logic signed [16:0] raw;
    logic signed [16:0] amp_a, amp_b;
    logic signed [33:0] prod;

    always_comb begin
        amp_a = tone_dual ? 17'(AMP_DUAL) : 17'(AMP_SINGLE);
        amp_b = tone_dual ? 17'(AMP_DUAL) : 17'h00000;
        raw = (phase_a_reg[PHASE_W-1] ? -amp_a : amp_a)
            + (phase_b_reg[PHASE_W-1] ? -amp_b : amp_b);
        prod = 34'(raw) * $signed({1'b0, gain});
        // Phases restart from zero so each tone burst starts alike
        phase_a_next = tone_on ? phase_a_reg + inc_a : '0;
        phase_b_next = (tone_on && tone_dual) ? phase_b_reg + inc_b : '0;
        sample_next = tone_on ? prod[GAIN_SHIFT +: 16] : 16'sh0000;
        active_next = tone_on;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_a_reg <= '0;
            phase_b_reg <= '0;
            sample_reg <= 16'sh0000;
            active_reg <= 1'b0;
        end else begin
            phase_a_reg <= phase_a_next;
            phase_b_reg <= phase_b_next;
            sample_reg <= sample_next;
            active_reg <= active_next;
        end
    end

    assign tx_sample = sample_reg;
    assign tx_active = active_reg;

endmodule : tone_synth
`default_nettype wire

// File: src/modem_tx_ctrl.sv
// Chosen here: the APB register port.
`default_nettype none
module modem_tx_ctrl
    import modem_ctrl_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic device_reset,
    output logic powered_up,
    output logic off_hook,
    output logic equaliser_disable,
    output logic loopback_off,
    output logic xtal_select,
    output logic irq_out_enable,
    output logic [GC_MASK_MSB:0] irq_mask,
    output logic guard_tone_enable,
    output logic signed [15:0] tx_sample,
    output logic tx_active
);

    ////////////////////////////////////////////////////////////////////////
    // APB register file

    logic [15:0] gen_ctrl_reg, gen_ctrl_next;
    logic [15:0] tx_mode_reg, tx_mode_next;
    logic [31:0] prdata_reg, prdata_next;
    logic hit_gc, hit_tm, hit_st, hit_any, wr_access;
    logic [15:0] status_word;

    always_comb begin
        hit_gc = (paddr == ADDR_GEN_CTRL);
        hit_tm = (paddr == ADDR_TX_MODE);
        hit_st = (paddr == ADDR_STATUS);
        hit_any = hit_gc || hit_tm || hit_st;
        wr_access = psel && penable && pwrite;
    end

    // Zero wait states; data is loaded during the setup cycle
    assign pready = 1'b1;
    assign pslverr = psel && penable && !hit_any;
    assign prdata = prdata_reg;

    always_comb begin
        gen_ctrl_next = gen_ctrl_reg;
        tx_mode_next = tx_mode_reg;
        if (wr_access && hit_gc) begin
            gen_ctrl_next = pwdata[15:0];
        end
        if (wr_access && hit_tm) begin
            tx_mode_next = pwdata[15:0];
        end
        prdata_next = prdata_reg;
        if (psel && !penable) begin
            if (hit_gc) begin
                prdata_next = {16'h0000, gen_ctrl_reg};
            end else if (hit_tm) begin
                prdata_next = {16'h0000, tx_mode_reg};
            end else if (hit_st) begin
                prdata_next = {16'h0000, status_word};
            end else begin
                prdata_next = 32'h00000000;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gen_ctrl_reg <= GEN_CTRL_RESET;
            tx_mode_reg <= TX_MODE_RESET;
            prdata_reg <= 32'h00000000;
        end else begin
            gen_ctrl_reg <= gen_ctrl_next;
            tx_mode_reg <= tx_mode_next;
            prdata_reg <= prdata_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // General control fields, plus the guard-tone bit of the transmit mode word

    always_comb begin
        device_reset = gen_ctrl_reg[GC_RESET_BIT];
        powered_up = gen_ctrl_reg[GC_POWER_BIT];
        off_hook = gen_ctrl_reg[GC_HOOK_BIT];
        equaliser_disable = gen_ctrl_reg[GC_EQDIS_BIT];
        loopback_off = !gen_ctrl_reg[GC_LOOP_BIT];
        xtal_select = gen_ctrl_reg[GC_XTAL_BIT];
        irq_out_enable = gen_ctrl_reg[GC_IRQEN_BIT];
        irq_mask = gen_ctrl_reg[GC_MASK_MSB:0];
        guard_tone_enable = tx_mode_reg[TM_GUARD_BIT];
    end

    ////////////////////////////////////////////////////////////////////////
    // Transmit mode decode

    tx_mode_t tx_mode;
    logic [4:0] tone_code;
    logic [2:0] fsk_data;
    logic [2:0] tx_level;
    logic tone_on, tone_dual, tx_run;
    logic [PHASE_W-1:0] inc_a, inc_b;
    logic [15:0] tone_gain;

    always_comb begin
        tx_mode = tx_mode_t'(tx_mode_reg[TM_MODE_MSB:TM_MODE_LSB]);
        tone_code = tx_mode_reg[TM_TONE_MSB:0];
        fsk_data = tx_mode_reg[TM_FSK_MSB:0];
        tx_level = tx_mode_reg[TM_LVL_MSB:TM_LVL_LSB];
        tone_gain = level_gain(tx_level);
        // Nothing leaves the transmitter while reset or powered down
        tx_run = powered_up && !device_reset;
        tone_on = 1'b0;
        tone_dual = 1'b0;
        inc_a = '0;
        inc_b = '0;
        case (tx_mode)
            TXM_TONE: begin
                case (tone_code)
                    TONE_1209: begin
                        inc_a = phase_inc(HZ_1209);
                        tone_on = 1'b1;
                    end
                    TONE_2100: begin
                        inc_a = phase_inc(HZ_2100);
                        tone_on = 1'b1;
                    end
                    TONE_DTMF_A: begin
                        inc_a = phase_inc(HZ_697);
                        inc_b = phase_inc(HZ_1633);
                        tone_dual = 1'b1;
                        tone_on = 1'b1;
                    end
                    TONE_DTMF_B: begin
                        inc_a = phase_inc(HZ_770);
                        inc_b = phase_inc(HZ_1633);
                        tone_dual = 1'b1;
                        tone_on = 1'b1;
                    end
                    default: begin
                        tone_on = 1'b0;
                    end
                endcase
            end
            TXM_FSK75: begin
                // Only the continuous-ones source has a data path here
                if (fsk_data == FSK_CONT_ONES) begin
                    inc_a = phase_inc(HZ_FSK75_MARK);
                    tone_on = 1'b1;
                end
            end
            default: begin
                tone_on = 1'b0;
            end
        endcase
        if (!tx_run) begin
            tone_on = 1'b0;
            tone_dual = 1'b0;
        end
    end

    tone_synth u_synth (
        .pclk(pclk),
        .presetn(presetn),
        .tone_on(tone_on),
        .tone_dual(tone_dual),
        .inc_a(inc_a),
        .inc_b(inc_b),
        .gain(tone_gain),
        .tx_sample(tx_sample),
        .tx_active(tx_active)
    );

    assign status_word = {11'h000, tx_mode == TXM_FSK75, tone_dual,
                          device_reset, powered_up, tx_active};

    ////////////////////////////////////////////////////////////////////////
    // Checks

    localparam logic signed [15:0] MIN_LVL_LIMIT = 16'sd4892;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_reset_silent;
        device_reset |=> (tx_sample == 16'sh0000) && !tx_active;
    endproperty
    a_reset_silent: assert property (p_reset_silent)
        else $error("transmitter not silent in reset");

    property p_tone_1209;
        (tx_mode_reg == 16'h1E05) && tx_run
            |-> inc_a == phase_inc(HZ_1209) && !tone_dual ##1 tx_active;
    endproperty
    a_tone_1209: assert property (p_tone_1209)
        else $error("1209 Hz tone not produced");

    property p_level_min;
        ($past(tx_level) == LVL_MIN) && tx_active && !$past(tone_dual)
            |-> (tx_sample <= MIN_LVL_LIMIT)
             && (tx_sample >= -MIN_LVL_LIMIT);
    endproperty
    a_level_min: assert property (p_level_min)
        else $error("minimum level not attenuated");

    property p_level_full;
        ($past(tx_level) == LVL_0DB) && tx_active && !$past(tone_dual)
            |-> (tx_sample > MIN_LVL_LIMIT) || (tx_sample < -MIN_LVL_LIMIT);
    endproperty
    a_level_full: assert property (p_level_full)
        else $error("full level too small");

    property p_tone_2100;
        (tx_mode_reg[TM_MODE_MSB:TM_MODE_LSB] == TXM_TONE)
            && (tone_code == TONE_2100) && tx_run
            |-> inc_a == phase_inc(HZ_2100) ##1 tx_active;
    endproperty
    a_tone_2100: assert property (p_tone_2100)
        else $error("2100 Hz tone not produced");

    property p_fsk_ones;
        (tx_mode_reg == 16'h4E1B) && tx_run
            |-> inc_a == phase_inc(HZ_FSK75_MARK) && !tone_dual
                ##1 tx_active;
    endproperty
    a_fsk_ones: assert property (p_fsk_ones)
        else $error("FSK continuous ones not sent");

    property p_dtmf_a;
        ((tx_mode_reg == 16'h1E1D) && tx_run) [*2]
            |-> tone_dual && inc_b == phase_inc(HZ_1633) && tx_active;
    endproperty
    a_dtmf_a: assert property (p_dtmf_a)
        else $error("DTMF A not held");

    property p_dtmf_b;
        (tx_mode_reg == 16'h1E1E) && tx_run
            |-> inc_a == phase_inc(HZ_770) && tone_dual ##1 tx_active;
    endproperty
    a_dtmf_b: assert property (p_dtmf_b)
        else $error("DTMF B not produced");

    property p_no_tone;
        (tx_mode_reg[TM_MODE_MSB:TM_MODE_LSB] == TXM_TONE)
            && (tone_code == TONE_NONE)
            |=> !tx_active && (tx_sample == 16'sh0000);
    endproperty
    a_no_tone: assert property (p_no_tone)
        else $error("no-tone code left output running");

    property p_write_takes_effect;
        wr_access && hit_tm && tx_run
            && (pwdata[15:0] == 16'h1E0A)
            |-> ##2 tx_active;
    endproperty
    a_write_takes_effect: assert property (p_write_takes_effect)
        else $error("transmit write did not take effect");

endmodule : modem_tx_ctrl
`default_nettype wire

// File: tb/host_model.sv
`default_nettype none
module host_model
    import modem_ctrl_pkg::*;
#(
    // Stands in for 100 ms; real time would need ten million cycles
    parameter int MS100_CYCLES = 100
)
(
    input wire logic pclk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    output logic [31:0] rd_data,
    output logic rd_err,
    output logic [15:0] rd_count
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h00000000;
        rd_data = 32'h00000000;
        rd_err = 1'b0;
        rd_count = 16'h0000;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic xfer(input logic wr, input logic [11:0] a,
                        input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd_data <= prdata;
        rd_err <= pslverr;
        rd_count <= rd_count + 16'h0001;
        psel <= 1'b0;
        penable <= 1'b0;
        // Released lines flip so stale values never pass for live ones
        paddr <= ~a;
        pwdata <= ~d;
    endtask : xfer

    // Host times the reset hold and each digit and gap itself
    task automatic pause_100ms();
        repeat (MS100_CYCLES) @(posedge pclk);
    endtask : pause_100ms

endmodule : host_model
`default_nettype wire

// File: tb/tb_top.sv
`default_nettype none
module tb_top
    import modem_ctrl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic pclk = 1'b0;
    logic presetn;
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic [31:0] rd_data;
    logic pready;
    logic pslverr;
    logic rd_err;
    logic [15:0] rd_count;
    logic device_reset;
    logic powered_up;
    logic off_hook;
    logic equaliser_disable;
    logic loopback_off;
    logic xtal_select;
    logic irq_out_enable;
    logic [GC_MASK_MSB:0] irq_mask;
    logic guard_tone_enable;
    logic signed [15:0] tx_sample;
    logic tx_active;
    logic [32:0] gc_seen;
    int num_errors = 0;
    int n_tests = 0;
    int cyc = 0;
    logic [33:0] exp_q[$];

    always #5 pclk = ~pclk;

    assign gc_seen = {20'h00000, device_reset, powered_up, off_hook,
        equaliser_disable, loopback_off, xtal_select, irq_out_enable,
        irq_mask};

    modem_tx_ctrl i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .device_reset(device_reset),
        .powered_up(powered_up), .off_hook(off_hook),
        .equaliser_disable(equaliser_disable),
        .loopback_off(loopback_off), .xtal_select(xtal_select),
        .irq_out_enable(irq_out_enable), .irq_mask(irq_mask),
        .guard_tone_enable(guard_tone_enable), .tx_sample(tx_sample),
        .tx_active(tx_active));

    host_model #(.MS100_CYCLES(100)) i_host (.pclk(pclk), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rd_data(rd_data), .rd_err(rd_err),
        .rd_count(rd_count));

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [32:0] seen, input logic [32:0] want);
        n_tests++;
        if (seen !== want) begin
            num_errors++;
            $display("unexpected at %0t: saw %h, want %h", $time, seen, want);
        end
    endtask : check

    task automatic tally_and_finish();
        if (num_errors == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : tally_and_finish

    task automatic wr(input logic [11:0] a, input logic [31:0] d,
                      input logic err);
        exp_q.push_back({1'b0, err, 32'h00000000});
        i_host.xfer(1'b1, a, d);
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [31:0] d,
                      input logic err);
        exp_q.push_back({1'b1, err, d});
        i_host.xfer(1'b0, a, 32'h00000000);
    endtask : rd

    task automatic tick();
        @(posedge pclk);
        #1;
    endtask : tick

    task automatic settle();
        repeat (2) tick();
    endtask : settle

    function automatic int mag(input logic signed [15:0] s);
        return (s < 0) ? -int'(s) : int'(s);
    endfunction : mag

    function automatic logic [32:0] gc_out(input logic [15:0] v);
        return {20'h00000, v[7], v[8], v[9], v[10], ~v[11], v[12], v[6],
            v[5:0]};
    endfunction : gc_out

    // Square wave from a zeroed phase: first half lasts CLK/(2*hz)
    task automatic tone_check(input int hz, input int lo, input int hi);
        int n;
        int m;
        logic s;
        n = 0;
        while (tx_active !== 1'b1 && n < 100) begin
            tick();
            n++;
        end
        s = tx_sample[15];
        m = mag(tx_sample);
        check({32'h0, lo <= m && m <= hi}, 33'h1);
        n = 1;
        while (tx_sample[15] === s && n < 60000) begin
            tick();
            n++;
        end
        m = n * 100;
        check({32'h0, m >= CLK_HZ / hz * 49 && m <= CLK_HZ / hz * 51},
            33'h1);
    endtask : tone_check

    ////////////////////////////////////////////////////////////////////////
    always @(rd_count) begin : mon
        logic [33:0] e;
        if (rd_count != 16'h0000) begin
            e = exp_q.pop_front();
            check({rd_err, rd_data & {32{e[33]}}}, e[32:0]);
        end
    end

    always @(posedge pclk) begin
        cyc++;
        if (cyc == 90000) begin
            num_errors++;
            tally_and_finish();
        end
    end

    initial begin
        logic [31:0] r;
        logic [15:0] v;
        presetn = 1'b0;
        r = $urandom(7);
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        settle();
        check(gc_seen, gc_out(16'h0000));
        check({16'h0, tx_sample, tx_active}, 33'h0);
        rd(ADDR_GEN_CTRL, 32'h0, 1'b0);
        rd(ADDR_TX_MODE, 32'h0, 1'b0);
        rd(12'h004, 32'h0, 1'b1);
        wr(12'h008, 32'h1234, 1'b1);
        wr(ADDR_GEN_CTRL, 32'h1180, 1'b0);
        settle();
        check(gc_seen, gc_out(16'h1180));
        rd(ADDR_STATUS, 32'h6, 1'b0);
        wr(ADDR_TX_MODE, 32'hFFFF1E05, 1'b0);
        settle();
        check({32'h0, tx_active}, 33'h0);
        rd(ADDR_TX_MODE, 32'h1E05, 1'b0);
        i_host.pause_100ms();
        wr(ADDR_GEN_CTRL, 32'h1100, 1'b0);
        tone_check(1209, 16'h3F00, 16'h4000);
        rd(ADDR_STATUS, 32'h3, 1'b0);
        wr(ADDR_TX_MODE, 32'h1005, 1'b0);
        settle();
        check({32'h0, mag(tx_sample) inside {[4800:4900]} && tx_active},
            33'h1);
        wr(ADDR_TX_MODE, 32'h1E00, 1'b0);
        settle();
        check({16'h0, tx_sample, tx_active}, 33'h0);
        rd(ADDR_STATUS, 32'h2, 1'b0);
        wr(ADDR_TX_MODE, 32'h1E0A, 1'b0);
        tone_check(2100, 16'h3F00, 16'h4000);
        wr(ADDR_TX_MODE, 32'h1E00, 1'b0);
        i_host.pause_100ms();
        for (int i = 0; i < 2; i++) begin
            wr(ADDR_TX_MODE, 32'h1E1D + i, 1'b0);
            settle();
            rd(ADDR_STATUS, 32'hB, 1'b0);
            i_host.pause_100ms();
            tick();
            // Two equal halves only ever sum to zero or full scale
            check({32'h0, tx_active && (mag(tx_sample) == 0
                || mag(tx_sample) >= 16'h3F00)}, 33'h1);
            wr(ADDR_TX_MODE, 32'h1E00, 1'b0);
            settle();
            check({16'h0, tx_sample, tx_active}, 33'h0);
            i_host.pause_100ms();
        end
        wr(ADDR_TX_MODE, 32'h4E1B, 1'b0);
        settle();
        check({31'h0, guard_tone_enable, tx_active}, 33'h1);
        rd(ADDR_STATUS, 32'h13, 1'b0);
        wr(ADDR_TX_MODE, 32'h4F1A, 1'b0);
        settle();
        check({31'h0, guard_tone_enable, tx_active}, 33'h2);
        // Status is read only; a write must leave it untouched
        wr(ADDR_STATUS, 32'hFFFF, 1'b0);
        rd(ADDR_STATUS, 32'h12, 1'b0);
        for (int i = 0; i < 4; i++) begin
            r = $urandom();
            v = {3'h0, r[12:8], 1'b0, r[6:0]};
            wr(ADDR_GEN_CTRL, {r[31:16], v}, 1'b0);
            settle();
            check(gc_seen, gc_out(v));
            rd(ADDR_GEN_CTRL, {16'h0, v}, 1'b0);
        end
        settle();
        tally_and_finish();
    end

endmodule : tb_top
`default_nettype wire
